// *** rtl/sarcc_cfg.svh ***
// Timing counts, field widths and trigger codes for the converter control.
// Assumes inclusion by bare name from rtl files; definitions only.
`ifndef SARCC_CFG_SVH
`define SARCC_CFG_SVH

`define SARCC_NUM_CH        8
`define SARCC_CH_W          3
`define SARCC_RES_W         10
`define SARCC_SAR_CYCLES    10
`define SARCC_DIV_W         6
`define SARCC_SHT_W         4
`define SARCC_TRG_TIMER0    3'h0
`define SARCC_TRG_TIMER1    3'h1
`define SARCC_TRG_TIMER2    3'h2
`define SARCC_TRG_EXT       3'h6
`define SARCC_FIFO_DEPTH    8
`define SARCC_FIFO_W        16

`endif

// *** rtl/sarcc_pkg.sv ***
// Types shared by the converter control design files.
// Assumes sarcc_cfg.svh holds the numeric constants.
`include "sarcc_cfg.svh"
package sarcc_pkg;
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_SAMPLE = 4'b0010,
        ST_CONV   = 4'b0100,
        ST_STORE  = 4'b1000
    } sarcc_state_e;
endpackage

// *** rtl/sarcc_clkdiv.sv ***
// Converter clock tick: one master-clock pulse per converter clock.
// Assumes prescale setting is static while the block is busy.
`timescale 1ns/100ps
`include "sarcc_cfg.svh"
module sarcc_clkdiv (
    input  wire logic                    core_clk_i,
    input  wire logic                    resetn_i,
    input  wire logic                    run_i,
    input  wire logic [`SARCC_DIV_W-1:0] div_i,
    output logic                         tick_o
);
    logic [`SARCC_DIV_W:0] cnt_r;
    logic [`SARCC_DIV_W:0] cnt_nxt;
    logic                  tick_nxt;
    logic [`SARCC_DIV_W:0] last;

    // Period is 2*(div+1) master clocks
    always_comb begin
        last     = {div_i, 1'b1};
        cnt_nxt  = '0;
        tick_nxt = 1'b0;
        if (run_i) begin
            if (cnt_r >= last) begin
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    // Register counter and tick
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r  <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_o <= tick_nxt;
        end
    end
endmodule

// *** rtl/sarcc_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes single clock; full and empty are exact.
`timescale 1ns/100ps
module sarcc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk_i,
    input  wire logic             resetn_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    wp_nxt;
    logic [AW-1:0]    rp_r;
    logic [AW-1:0]    rp_nxt;
    logic [AW:0]      cnt_r;
    logic [AW:0]      cnt_nxt;
    logic             wr;
    logic             rd;

    assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem[rp_r];
    assign wr          = in_valid_i && in_ready_o;
    assign rd          = out_valid_o && out_ready_i;

    // Pointer and level update
    always_comb begin
        wp_nxt  = wp_r;
        rp_nxt  = rp_r;
        cnt_nxt = cnt_r;
        if (wr) begin
            wp_nxt = (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
        end
        if (rd) begin
            rp_nxt = (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
        end
        if (wr && !rd) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (rd && !wr) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // Register pointers
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage write
    always_ff @(posedge core_clk_i) begin
        if (wr) begin
            mem[wp_r] <= in_data_i;
        end
    end
endmodule

// *** rtl/sarcc_top.sv ***
// Conversion control for an eight-channel successive-approximation converter.
// Assumes control bits as plain ports, analog cell below, DMA above.
// Overview of operation
// - Conversion takes sample-hold cycles plus one, then 10 converter clock cycles.
// - Converter clock is master clock over 2*(divider+1), range /2 to /128.
// - Out of reset the resolution is 10 bits.
// - Low resolution keeps eight high bits, shifted down; upper two bits read zero.
// - DMA words are 16 bits, or 8 bits in low resolution.
// - Result goes to the channel register and the last-result register.
// - Completion sets channel end-of-conversion flag and result-ready flag.
// - Each completion issues a DMA transfer request.
// - End-of-conversion and result-ready flags can raise the interrupt.
// - Reading a channel register clears its end-of-conversion flag.
// - Reading last result clears ready flag and last channel's flag.
// - New result on unread channel sets that channel's overrun flag.
// - Completion while result-ready is set sets general overrun flag.
// - Reading status clears channel and general overrun flags.
// - One of eight inputs is selected through an eight-way mux.
// - Start by software, external pin rising edge, or timer outputs.
// - Enabling a channel hands its shared pin to the converter.
// - Trigger select: 0..2 timers, 6 external pin, others reserved.
// - One start converts all enabled channels; software start works with or without hardware trigger enable.
// - Hardware trigger starts after two master clocks or more.
`timescale 1ns/100ps
`include "sarcc_cfg.svh"
module sarcc_top #(
    parameter int NUM_CH     = `SARCC_NUM_CH,
    parameter int FIFO_DEPTH = `SARCC_FIFO_DEPTH
) (
    input  wire logic                     core_clk_i,
    input  wire logic                     resetn_i,
    input  wire logic                     soft_start_i,
    input  wire logic                     hardware_trigger_enable_i,
    input  wire logic [2:0]               trigger_source_select_i,
    input  wire logic [2:0]               timer_waveform_output_i,
    input  wire logic                     external_trigger_pin_i,
    input  wire logic                     low_resolution_select_i,
    input  wire logic [`SARCC_DIV_W-1:0]  conv_clock_divider_i,
    input  wire logic [`SARCC_SHT_W-1:0]  sample_hold_cycles_i,
    input  wire logic [NUM_CH-1:0]        channel_enable_i,
    input  wire logic [NUM_CH-1:0]        chan_result_rd_i,
    input  wire logic                     last_result_rd_i,
    input  wire logic                     status_rd_i,
    input  wire logic                     sar_compare_i,
    input  wire logic                     dma_ready_i,
    output logic                          sar_sample_o,
    output logic [`SARCC_CH_W-1:0]        mux_select_o,
    output logic [NUM_CH-1:0]             pin_to_converter_o,
    output logic [`SARCC_RES_W-1:0]       sar_trial_o,
    output logic                          busy_o,
    output logic [`SARCC_RES_W*NUM_CH-1:0] channel_result_o,
    output logic [`SARCC_RES_W-1:0]       last_result_field_o,
    output logic [NUM_CH-1:0]             eoc_flag_o,
    output logic                          result_ready_flag_o,
    output logic [NUM_CH-1:0]             channel_overrun_flag_o,
    output logic                          general_overrun_flag_o,
    output logic                          irq_o,
    output logic                          dma_valid_o,
    output logic [`SARCC_FIFO_W-1:0]      dma_data_o,
    output logic                          dma_byte_mode_o
);
    localparam int RW = `SARCC_RES_W;
    localparam int CW = `SARCC_CH_W;

    sarcc_pkg::sarcc_state_e st_r, st_nxt;
    logic [NUM_CH-1:0] pend_r, pend_nxt;
    logic [CW-1:0]     ch_r, ch_nxt;
    logic [4:0]        cyc_r, cyc_nxt;
    logic [RW-1:0]     sar_r, sar_nxt;
    logic              trg_d1_r, trg_d2_r, hw_arm_r;
    logic              trg_nxt, hw_fire;
    logic              start;
    logic              tick;
    logic [RW-1:0]     res_fmt;
    logic [CW-1:0]     first_ch;
    logic              any_pend;
    logic [RW*NUM_CH-1:0] cdr_nxt;
    logic [RW-1:0]     ldr_nxt;
    logic [NUM_CH-1:0] eoc_nxt, ovr_nxt;
    logic              rdy_nxt, govr_nxt, done;
    logic [CW-1:0]     last_ch_r, last_ch_nxt;
    logic              fifo_in_ready, fifo_out_valid;
    logic [`SARCC_FIFO_W-1:0] fifo_out_data;
    logic              dma_take;

    // Converter clock ticks only while a sequence runs
    sarcc_clkdiv u_div (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .run_i      (st_r != sarcc_pkg::ST_IDLE),
        .div_i      (conv_clock_divider_i),
        .tick_o     (tick)
    );

    // Hardware trigger source selection
    always_comb begin
        trg_nxt = 1'b0;
        if (trigger_source_select_i == `SARCC_TRG_TIMER0) begin
            trg_nxt = timer_waveform_output_i[0];
        end else if (trigger_source_select_i == `SARCC_TRG_TIMER1) begin
            trg_nxt = timer_waveform_output_i[1];
        end else if (trigger_source_select_i == `SARCC_TRG_TIMER2) begin
            trg_nxt = timer_waveform_output_i[2];
        end else if (trigger_source_select_i == `SARCC_TRG_EXT) begin
            trg_nxt = external_trigger_pin_i;
        end
    end

    // Rising edge of the selected source, two-cycle latency
    assign hw_fire = hardware_trigger_enable_i && trg_d1_r && !trg_d2_r;
    assign start   = soft_start_i || (hw_arm_r);

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            trg_d1_r <= 1'b0;
            trg_d2_r <= 1'b0;
            hw_arm_r <= 1'b0;
        end else begin
            trg_d1_r <= trg_nxt;
            trg_d2_r <= trg_d1_r;
            hw_arm_r <= hw_fire;
        end
    end

    // Lowest pending channel
    always_comb begin
        first_ch = '0;
        any_pend = |pend_r;
        for (int i = NUM_CH-1; i >= 0; i--) begin
            if (pend_r[i]) begin
                first_ch = CW'(i);
            end
        end
    end

    // Result with final trial bit; 8-bit mode zeroes the top two bits
    assign res_fmt = low_resolution_select_i
                   ? {2'h0, sar_nxt[RW-1:2]} : sar_nxt;

    // Sequencer: sample phase then 10 bit trials per channel
    always_comb begin
        st_nxt  = st_r;
        pend_nxt = pend_r;
        ch_nxt  = ch_r;
        cyc_nxt = cyc_r;
        sar_nxt = sar_r;
        done    = 1'b0;
        case (st_r)
            sarcc_pkg::ST_IDLE: begin
                if (start && (|channel_enable_i) && fifo_in_ready) begin
                    pend_nxt = channel_enable_i;
                    st_nxt   = sarcc_pkg::ST_STORE;
                end
            end
            sarcc_pkg::ST_SAMPLE: begin
                if (tick) begin
                    if (cyc_r >= 5'(sample_hold_cycles_i)) begin
                        cyc_nxt = '0;
                        sar_nxt = 10'h200;
                        st_nxt  = sarcc_pkg::ST_CONV;
                    end else begin
                        cyc_nxt = cyc_r + 5'h01;
                    end
                end
            end
            sarcc_pkg::ST_CONV: begin
                if (tick) begin
                    // Keep or drop the trial bit, then try the next one
                    for (int b = 0; b < RW; b++) begin
                        if (5'(RW-1-b) == cyc_r) begin
                            sar_nxt[b] = sar_compare_i;
                            if (b > 0) begin
                                sar_nxt[b-1] = 1'b1;
                            end
                        end
                    end
                    if (cyc_r == 5'(`SARCC_SAR_CYCLES-1)) begin
                        done   = 1'b1;
                        st_nxt = sarcc_pkg::ST_STORE;
                    end else begin
                        cyc_nxt = cyc_r + 5'h01;
                    end
                end
            end
            sarcc_pkg::ST_STORE: begin
                // Pick next channel or finish; ignore triggers meanwhile
                if (any_pend && fifo_in_ready) begin
                    ch_nxt   = first_ch;
                    pend_nxt[first_ch] = 1'b0;
                    cyc_nxt  = '0;
                    st_nxt   = sarcc_pkg::ST_SAMPLE;
                end else if (!any_pend) begin
                    st_nxt   = sarcc_pkg::ST_IDLE;
                end
            end
            default: st_nxt = sarcc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r   <= sarcc_pkg::ST_IDLE;
            pend_r <= '0;
            ch_r   <= '0;
            cyc_r  <= '0;
            sar_r  <= '0;
        end else begin
            st_r   <= st_nxt;
            pend_r <= pend_nxt;
            ch_r   <= ch_nxt;
            cyc_r  <= cyc_nxt;
            sar_r  <= sar_nxt;
        end
    end

    // Result registers and flags; a completion beats a same-cycle clear
    always_comb begin
        cdr_nxt     = channel_result_o;
        ldr_nxt     = last_result_field_o;
        eoc_nxt     = eoc_flag_o & ~chan_result_rd_i;
        rdy_nxt     = result_ready_flag_o;
        ovr_nxt     = channel_overrun_flag_o;
        govr_nxt    = general_overrun_flag_o;
        last_ch_nxt = last_ch_r;
        if (last_result_rd_i) begin
            rdy_nxt = 1'b0;
            eoc_nxt[last_ch_r] = 1'b0;
        end
        if (status_rd_i) begin
            ovr_nxt  = '0;
            govr_nxt = 1'b0;
        end
        if (done) begin
            cdr_nxt[ch_r*RW +: RW] = res_fmt;
            ldr_nxt     = res_fmt;
            last_ch_nxt = ch_r;
            if (eoc_flag_o[ch_r] && !chan_result_rd_i[ch_r]) begin
                ovr_nxt[ch_r] = 1'b1;
            end
            if (result_ready_flag_o && !last_result_rd_i) begin
                govr_nxt = 1'b1;
            end
            eoc_nxt[ch_r] = 1'b1;
            rdy_nxt       = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            channel_result_o       <= '0;
            last_result_field_o    <= '0;
            eoc_flag_o             <= '0;
            result_ready_flag_o    <= 1'b0;
            channel_overrun_flag_o <= '0;
            general_overrun_flag_o <= 1'b0;
            last_ch_r              <= '0;
        end else begin
            channel_result_o       <= cdr_nxt;
            last_result_field_o    <= ldr_nxt;
            eoc_flag_o             <= eoc_nxt;
            result_ready_flag_o    <= rdy_nxt;
            channel_overrun_flag_o <= ovr_nxt;
            general_overrun_flag_o <= govr_nxt;
            last_ch_r              <= last_ch_nxt;
        end
    end

    // Each completion pushes one word toward DMA
    sarcc_fifo #(
        .WIDTH (`SARCC_FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i  (core_clk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (done),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   ({6'h00, res_fmt}),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (dma_take),
        .out_data_o  (fifo_out_data)
    );

    // Registered DMA stage: load when empty or consumed
    assign dma_take = fifo_out_valid && (!dma_valid_o || dma_ready_i);

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dma_valid_o     <= 1'b0;
            dma_data_o      <= '0;
            dma_byte_mode_o <= 1'b0;
        end else begin
            if (dma_take) begin
                dma_valid_o <= 1'b1;
                dma_data_o  <= fifo_out_data;
            end else if (dma_ready_i) begin
                dma_valid_o <= 1'b0;
            end
            dma_byte_mode_o <= low_resolution_select_i;
        end
    end

    // Analog-side controls, pin handover, interrupt
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sar_sample_o       <= 1'b0;
            mux_select_o       <= '0;
            pin_to_converter_o <= '0;
            sar_trial_o        <= '0;
            busy_o             <= 1'b0;
            irq_o              <= 1'b0;
        end else begin
            sar_sample_o       <= (st_nxt == sarcc_pkg::ST_SAMPLE);
            mux_select_o       <= ch_nxt;
            pin_to_converter_o <= channel_enable_i;
            sar_trial_o        <= sar_nxt;
            busy_o             <= (st_nxt != sarcc_pkg::ST_IDLE);
            irq_o              <= (|eoc_nxt) || rdy_nxt;
        end
    end
endmodule

// *** test/sarcc_far_model.sv ***
// Comparator cell and DMA channel beside the converter control.
// Assumes input levels come from the bench.
`timescale 1ns/100ps
module sarcc_far_model (
    input  wire logic        core_clk_i,
    input  wire logic [79:0] level_i,
    input  wire logic [2:0]  mux_select_i,
    input  wire logic [9:0]  sar_trial_i,
    input  wire logic        sar_sample_i,
    input  wire logic        stall_i,
    output logic             sar_compare_o,
    output logic             dma_ready_o
);
    logic [3:0] cnt_r = 4'h0;

    // Comparator on the selected line; toggles while sampling
    assign sar_compare_o = sar_sample_i ? cnt_r[0] :
        (level_i[mux_select_i*10 +: 10] >= sar_trial_i);

    // DMA accepts three cycles of four, none while held off
    always @(posedge core_clk_i) begin
        #1;
        cnt_r = cnt_r + 4'h1;
        dma_ready_o = !stall_i && (cnt_r[1:0] != 2'h3);
    end
endmodule

// *** test/sarcc_top_checker.sv ***
// Port-level assertions on the converter control.
// Assumes one clock and an active-low reset.
`timescale 1ns/100ps
`include "sarcc_cfg.svh"
module sarcc_top_checker #(
    parameter int NUM_CH = 8
) (
    input wire logic                     core_clk_i,
    input wire logic                     resetn_i,
    input wire logic [NUM_CH-1:0]        channel_enable_i,
    input wire logic [NUM_CH-1:0]        chan_result_rd_i,
    input wire logic                     last_result_rd_i,
    input wire logic                     status_rd_i,
    input wire logic                     low_resolution_select_i,
    input wire logic                     dma_ready_i,
    input wire logic                     sar_sample_o,
    input wire logic [`SARCC_CH_W-1:0]   mux_select_o,
    input wire logic [NUM_CH-1:0]        pin_to_converter_o,
    input wire logic                     busy_o,
    input wire logic [`SARCC_RES_W-1:0]  last_result_field_o,
    input wire logic [NUM_CH-1:0]        eoc_flag_o,
    input wire logic                     result_ready_flag_o,
    input wire logic [NUM_CH-1:0]        channel_overrun_flag_o,
    input wire logic                     general_overrun_flag_o,
    input wire logic                     irq_o,
    input wire logic                     dma_valid_o,
    input wire logic [`SARCC_FIFO_W-1:0] dma_data_o,
    input wire logic                     dma_byte_mode_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    // Flag, read-clear and data-path relations
    a_pin_follow_en: assert property (
        $past(resetn_i) |-> pin_to_converter_o == $past(channel_enable_i))
        else $error("pin hand-over lags enable");
    a_irq_from_flags: assert property (
        irq_o == ((|eoc_flag_o) | result_ready_flag_o))
        else $error("interrupt does not follow flags");
    a_ready_has_eoc: assert property (
        $rose(result_ready_flag_o) |-> eoc_flag_o != '0)
        else $error("ready set without channel flag");
    a_last_read_clr: assert property (
        last_result_rd_i && !busy_o |=> !result_ready_flag_o)
        else $error("last read left ready set");
    a_status_read_clr: assert property (
        status_rd_i && !busy_o |=>
            channel_overrun_flag_o == '0 && !general_overrun_flag_o)
        else $error("status read left overrun set");
    a_chan_read_clr: assert property (
        chan_result_rd_i != '0 && !busy_o |=>
            (eoc_flag_o & $past(chan_result_rd_i)) == '0)
        else $error("channel read left flag set");
    a_sample_enabled: assert property (
        sar_sample_o |-> channel_enable_i[mux_select_o])
        else $error("sampling a disabled channel");
    a_low_resolution_select_top_zero: assert property (
        low_resolution_select_i && $changed(last_result_field_o) |->
            last_result_field_o[9:8] == 2'h0)
        else $error("low resolution upper bits set");
    a_dma_width: assert property (
        dma_valid_o |-> dma_data_o[15:10] == 6'h0 &&
            (!dma_byte_mode_o || dma_data_o[9:8] == 2'h0))
        else $error("DMA word wider than mode");
    a_ready_to_dma: assert property (
        $rose(result_ready_flag_o) |-> ##[0:4] dma_valid_o)
        else $error("no DMA request after ready");

    // Main scenarios reached
    c_general_ovr: cover property (general_overrun_flag_o);
    c_dma_stall: cover property (dma_valid_o && !dma_ready_i);
    c_low_resolution_select_busy: cover property (busy_o && low_resolution_select_i);
endmodule

bind sarcc_top sarcc_top_checker #(.NUM_CH(NUM_CH)) u_chk (.*);

// *** test/tb_sar_adc_conversion_control.sv ***
// Self-checking bench for the converter control.
// Assumes a 40 MHz master clock.
`timescale 1ns/100ps
module tb_sar_adc_conversion_control;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        sst, hwen, ext, lres, srd, lrd, stall;
    logic        cmp, result_ready_flag, smp, busy, rdy, govr, irq, dval, dbyte;
    logic [2:0]  tsel, tmr, mux;
    logic [5:0]  div;
    logic [3:0]  sht;
    logic [7:0]  en, crd, pin, eoc, ovr;
    logic [79:0] lvl, cres;
    logic [9:0]  trial, lastv;
    logic [15:0] ddat;
    logic [15:0] gotq[$], exq[$];
    logic [2:0]  codes[5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h3};
    int          error_cnt = 0;
    int          checks_done = 0;
    int          cyc_cnt = 0, tno = 0;

    sarcc_top uut (
        .core_clk_i(core_clk), .resetn_i(resetn), .soft_start_i(sst),
        .hardware_trigger_enable_i(hwen), .trigger_source_select_i(tsel),
        .timer_waveform_output_i(tmr), .external_trigger_pin_i(ext),
        .low_resolution_select_i(lres), .conv_clock_divider_i(div),
        .sample_hold_cycles_i(sht), .channel_enable_i(en),
        .chan_result_rd_i(crd), .last_result_rd_i(lrd), .status_rd_i(srd),
        .sar_compare_i(cmp), .dma_ready_i(result_ready_flag), .sar_sample_o(smp),
        .mux_select_o(mux), .pin_to_converter_o(pin), .sar_trial_o(trial),
        .busy_o(busy), .channel_result_o(cres), .last_result_field_o(lastv),
        .eoc_flag_o(eoc), .result_ready_flag_o(rdy),
        .channel_overrun_flag_o(ovr), .general_overrun_flag_o(govr),
        .irq_o(irq), .dma_valid_o(dval), .dma_data_o(ddat),
        .dma_byte_mode_o(dbyte));

    sarcc_far_model far (
        .core_clk_i(core_clk), .level_i(lvl), .mux_select_i(mux),
        .sar_trial_i(trial), .sar_sample_i(smp), .stall_i(stall),
        .sar_compare_o(cmp), .dma_ready_o(result_ready_flag));

    // Master clock, 25 ns period
    always #12.5 core_clk = ~core_clk;

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wait_busy(input logic t, input int lim, input logic e);
        int i = 0;
        while (busy !== t && i < lim) begin
            cyc(1);
            i++;
        end
        chk(busy, e);
    endtask

    task automatic rd(input logic [7:0] c, input logic l, input logic s);
        {crd, lrd, srd} = {c, l, s};
        cyc(1);
        {crd, lrd, srd} = '0;
        cyc(1);
    endtask

    task automatic drain;
        int i = 0;
        while (gotq.size() < exq.size() && i < 4000) begin
            cyc(1);
            i++;
        end
        tno++;
        $display("test %0d done", tno);
    endtask

    // One started sequence with a retrigger while busy
    task automatic run_seq(input logic [7:0] m, input logic lo);
        int n, e, c;
        logic [9:0] v;
        en = m;
        lres = lo;
        lvl = 80'({$urandom, $urandom, $urandom});
        lvl[9:0] = 10'h3FF;
        cyc(1);
        sst = 1'b1;
        cyc(1);
        wait_busy(1'b1, 4, 1'b1);
        cyc(1);
        sst = 1'b0;
        if (rdy === 1'b0) begin
            n = 0;
            while (rdy !== 1'b1 && n < 5000) begin
                cyc(1);
                n++;
            end
            e = (int'(sht) + 11) * 2 * (int'(div) + 1);
            chk(32'(n + 2 >= e && n <= e + 2), 32'h1);
        end
        wait_busy(1'b0, 20000, 1'b0);
        cyc(3);
        chk(busy, 1'b0);
        for (c = 0; c < 8; c++) begin
            if (m[c]) begin
                v = lo ? {2'h0, lvl[c*10+2 +: 8]} : lvl[c*10 +: 10];
                chk(cres[c*10 +: 10], v);
                exq.push_back({6'h0, v});
            end
        end
        chk(lastv, v);
        chk(eoc, m);
        chk(rdy, 1'b1);
    endtask

    // Cycle limit against hangs
    always @(posedge core_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 60000) begin
            error_cnt++;
            finish_test;
        end
    end

    // DMA words taken at the following rising edge
    always @(negedge core_clk) begin
        if (dval === 1'b1 && result_ready_flag === 1'b1) begin
            gotq.push_back(ddat);
            chk(dbyte, lres);
        end
    end

    // Main sequence
    initial begin
        {sst, hwen, ext, lres, srd, lrd, stall} = '0;
        {tsel, tmr, div, sht, en, crd} = '0;
        lvl = '0;
        void'($urandom(32'hE25EB107));
        repeat (12) @(posedge core_clk);
        #1 resetn = 1'b1;
        chk({eoc, rdy, govr, irq, busy, lastv}, 32'h0);
        for (int k = 0; k < 4; k++) begin
            div = 6'(1 + $urandom % 3);
            sht = 4'($urandom);
            run_seq(k == 0 ? 8'h81 : 8'($urandom % 255 + 1), 1'b0);
            if (k == 0) begin
                run_seq(8'h81, 1'b0);
                chk(ovr, 8'h81);
                chk(govr, 1'b1);
                rd(8'h00, 1'b0, 1'b1);
                chk({ovr, govr}, 9'h0);
                rd(8'h01, 1'b0, 1'b0);
                chk(eoc, 8'h80);
                rd(8'h00, 1'b1, 1'b0);
                chk({eoc, rdy}, 9'h0);
            end
            drain;
            rd(8'hFF, 1'b1, 1'b1);
        end
        run_seq(8'($urandom) | 8'h20, 1'b1);
        drain;
        rd(8'hFF, 1'b1, 1'b1);
        div = 6'h00;
        sht = 4'hF;
        run_seq(8'h10, 1'b0);
        rd(8'hFF, 1'b1, 1'b1);
        div = 6'h3F;
        sht = 4'h0;
        run_seq(8'h04, 1'b0);
        drain;
        rd(8'hFF, 1'b1, 1'b1);
        en = 8'h00;
        sst = 1'b1;
        cyc(1);
        sst = 1'b0;
        cyc(3);
        chk({busy, rdy, eoc}, 10'h0);
        div = 6'h00;
        en = 8'h02;
        hwen = 1'b1;
        foreach (codes[i]) begin
            tsel = codes[i];
            cyc(2);
            tmr = (codes[i] == 3'h3) ? 3'h7 : 3'(1 << codes[i]);
            ext = (codes[i] == 3'h6 || codes[i] == 3'h3);
            wait_busy(1'b1, 6, codes[i] != 3'h3);
            if (codes[i] != 3'h3)
                exq.push_back({6'h0, lvl[19:10]});
            wait_busy(1'b0, 2000, 1'b0);
            {tmr, ext} = '0;
            rd(8'hFF, 1'b1, 1'b1);
        end
        run_seq(8'h06, 1'b0);
        hwen = 1'b0;
        drain;
        rd(8'hFF, 1'b1, 1'b1);
        stall = 1'b1;
        run_seq(8'hFF, 1'b0);
        sst = 1'b1;
        cyc(1);
        sst = 1'b0;
        cyc(4);
        chk(busy, 1'b1);
        chk(gotq.size() + 8, exq.size());
        for (int c = 0; c < 8; c++)
            exq.push_back({6'h0, lvl[c*10 +: 10]});
        stall = 1'b0;
        drain;
        chk(gotq.size(), exq.size());
        foreach (exq[i])
            if (i < gotq.size())
                chk(gotq[i], exq[i]);
        finish_test;
    end
endmodule
